// ### verilog/spd_wp_cfg.svh
// Constants for the write-protect and acknowledge block
`ifndef SPD_WP_CFG_SVH
`define SPD_WP_CFG_SVH

// ----------------------------------------
// Select and address byte decode
// ----------------------------------------
`define DEV_TYPE_MEM 4'hA
`define DEV_TYPE_PROT 4'h6
`define SET_SEL_BITS 3'h1
`define CLR_SEL_BITS 3'h3
`define LOW_HALF_BIT 7
`define PAGE_BITS 4

// ----------------------------------------
// Synchronised pin vector positions
// ----------------------------------------
`define PIN_SCL 0
`define PIN_SDA 1
`define PIN_SEL0 2
`define PIN_SEL1 3
`define PIN_SEL2 4
`define PIN_HV 5
`define PIN_INHIBIT 6
`define PIN_COUNT 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_KHZ 20000
`define WRITE_CYCLE_TIME_MS 10
`define WRITE_CNT_W 24

`endif

// ### verilog/spd_wp_pkg.sv
// Types for the write-protect and acknowledge block
package spd_wp_pkg;

  // Byte engine states, Gray along idle, receive, acknowledge
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RX = 2'h1,
    BUS_ACK = 2'h3,
    BUS_SKIP = 2'h2
  } bus_state_t;

  // Protection level held in nonvolatile storage
  typedef enum logic [1:0] {
    PROT_NONE = 2'h0,
    PROT_SOFT = 2'h1,
    PROT_PERM = 2'h3
  } prot_state_t;

  // Decoded instruction
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_MEM = 3'h1,
    CMD_SET = 3'h2,
    CMD_CLR = 3'h3,
    CMD_LOCK = 3'h4
  } cmd_t;

endpackage : spd_wp_pkg

// ### verilog/pin_sampler.sv
// Pin synchronisers and bus start, stop and clock edge detection
`timescale 1ns/1ps
`include "spd_wp_cfg.svh"

module pin_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins
  input wire logic [`PIN_COUNT-1:0] pins_raw,
  // Synchronised levels and events
  output logic [`PIN_COUNT-1:0] pins_sync,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  logic [`PIN_COUNT-1:0] stage1;
  logic scl_prev;
  logic sda_prev;

  // ----------------------------------------
  // Two-flop synchronisers, one per pin
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1[i] <= 1'b1;
          pins_sync[i] <= 1'b1;
        end else begin
          stage1[i] <= pins_raw[i];
          pins_sync[i] <= stage1[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Edge history of clock and data lines
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= pins_sync[`PIN_SCL];
      sda_prev <= pins_sync[`PIN_SDA];
    end
  end

  // Data edges while clock stays high are start and stop
  always_comb begin
    scl_rise = pins_sync[`PIN_SCL] && !scl_prev;
    scl_fall = !pins_sync[`PIN_SCL] && scl_prev;
    start_det = scl_prev && pins_sync[`PIN_SCL] && sda_prev && !pins_sync[`PIN_SDA];
    stop_det = scl_prev && pins_sync[`PIN_SCL] && !sda_prev && pins_sync[`PIN_SDA];
  end

endmodule : pin_sampler

// ### verilog/spd_write_protect_ack.sv
// Write-protect state machine and acknowledge policy of the presence-detect memory
//
// Behaviour
// [R01] Answer only selects whose chip bits equal the three chip-enable pin levels; set and clear selects are acked on fixed bits.
// [R02] Programmer holds the qualifier high from start to stop for set or clear.
// [R03] Lock instruction is accepted without the high-voltage qualifier.
// [R04] Programmer clears, rewrites the low 128 bytes, then locks.
// [R05] Locked: write-form protect instruction gets no acknowledge anywhere, no write cycle.
// [R06] Protected: low-half write acks select and address, refuses data, no cycle.
// [R07] Soft-protected: repeated set gets no acknowledge on any byte, no cycle.
// [R08] Soft, inhibit low: clear acked fully, write cycle returns to unprotected.
// [R09] Soft, inhibit low: lock acked fully, write cycle enters locked state.
// [R10] Inhibit high: select and address acked, data refused, no write cycle.
// [R11] Unprotected, inhibit low: protect instruction acked fully and applied.
// [R12] Unprotected, inhibit low: memory write acked fully and write cycle started.
// [R13] Locked: read-form protect instruction gets no acknowledge on any byte.
// [R14] Soft: read-form set refused; clear and lock selects acked, rest refused.
// [R15] Unprotected: read-form protect select acked, following bytes refused.
// [R16] Master reads protection state from which read-form selects are acked.
// [R17] Protect instructions use their own type code; refused once locked.
// [R18] Software protection covers only the lower half of the array.
// [R19] Protection state is kept in nonvolatile storage across power cycles.
// [R20] Write cycle starts only on a stop directly after an acknowledge slot.
// [R21] Set and clear need the high-voltage qualifier for the whole instruction.
`timescale 1ns/1ps
`include "spd_wp_cfg.svh"

module spd_write_protect_ack
  import spd_wp_pkg::*;
#(
  parameter int WRITE_CYCLE_CYCLES = `WRITE_CYCLE_TIME_MS * `CLK_FREQ_KHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Position and control pins
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  input wire logic chip_sel_bit2,
  input wire logic e0_high_voltage_level,
  input wire logic write_inhibit_in,
  // Nonvolatile protection storage
  input wire prot_state_t nv_protect_init,
  output prot_state_t protect_state,
  // Write cycle status
  output logic write_busy,
  output logic mem_write_go
);

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  logic [`PIN_COUNT-1:0] pins_sync;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  pin_sampler u_sampler (
    .clk(clk),
    .arst_n(arst_n),
    .pins_raw({write_inhibit_in, e0_high_voltage_level, chip_sel_bit2,
               chip_sel_bit1, chip_sel_bit0, sda_in, scl_in}),
    .pins_sync(pins_sync),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  logic sda_s;
  logic hv_s;
  logic inhibit_s;
  logic [2:0] pins_pos;

  assign sda_s = pins_sync[`PIN_SDA];
  assign hv_s = pins_sync[`PIN_HV];
  assign inhibit_s = pins_sync[`PIN_INHIBIT];
  assign pins_pos = {pins_sync[`PIN_SEL2], pins_sync[`PIN_SEL1], pins_sync[`PIN_SEL0]};

  // ----------------------------------------
  // Byte engine state
  // ----------------------------------------
  bus_state_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [1:0] byte_idx, next_byte_idx;
  cmd_t cmd, next_cmd;
  logic rw, next_rw;
  logic [7:0] addr_ptr, next_addr_ptr;
  logic hv_ok, next_hv_ok;
  logic after_ack, next_after_ack;
  logic next_sda_oe;
  logic go_write;

  // ----------------------------------------
  // Write cycle and protection state
  // ----------------------------------------
  prot_state_t next_protect_state;
  prot_state_t pend_state, next_pend_state;
  logic pend_prot, next_pend_prot;
  logic next_write_busy;
  logic next_mem_write_go;
  logic nv_loaded, next_nv_loaded;
  logic [`WRITE_CNT_W-1:0] wcnt, next_wcnt;

  // Select byte decode and acknowledge decision
  cmd_t dec_cmd;
  logic ack_now;

  always_comb begin
    dec_cmd = CMD_NONE;
    if (shreg[7:4] == `DEV_TYPE_MEM && shreg[3:1] == pins_pos) begin
      dec_cmd = CMD_MEM; // R01
    end else if (shreg[7:4] == `DEV_TYPE_PROT) begin // R17
      if (hv_ok && hv_s && shreg[3:1] == `SET_SEL_BITS) begin
        dec_cmd = CMD_SET; // R21
      end else if (hv_ok && hv_s && shreg[3:1] == `CLR_SEL_BITS) begin
        dec_cmd = CMD_CLR; // R21
      end else if (shreg[3:1] == pins_pos) begin
        dec_cmd = CMD_LOCK; // R03
      end
    end
    ack_now = 1'b0;
    if (byte_idx == 2'h0) begin
      if (dec_cmd == CMD_MEM) begin
        ack_now = 1'b1;
      end else if (dec_cmd != CMD_NONE) begin
        // Locked refuses all; soft refuses a repeated set
        ack_now = !(protect_state == PROT_PERM) &&
                  !(protect_state == PROT_SOFT && dec_cmd == CMD_SET); // R05 R13 R07 R14 R15
      end
    end else if (byte_idx == 2'h1) begin
      ack_now = !rw; // R15
    end else if (cmd == CMD_MEM) begin
      ack_now = !inhibit_s && // R10
                !(protect_state != PROT_NONE && !addr_ptr[`LOW_HALF_BIT]); // R06 R18
    end else begin
      ack_now = !inhibit_s; // R08 R09 R10 R11
    end
  end

  // Stop right after an acknowledged data byte starts the cycle
  always_comb begin
    go_write = stop_det && (state == BUS_RX) && after_ack && byte_idx == 2'h3 && !rw; // R20
    if (cmd == CMD_SET || cmd == CMD_CLR) begin
      go_write = go_write && hv_ok && hv_s; // R21
    end
  end

  // ----------------------------------------
  // Byte engine next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_cmd = cmd;
    next_rw = rw;
    next_addr_ptr = addr_ptr;
    next_hv_ok = hv_ok && hv_s;
    next_after_ack = after_ack;
    next_sda_oe = sda_oe;
    if (write_busy || !nv_loaded) begin
      // Bus ignored during the write cycle
      next_state = BUS_IDLE;
      next_sda_oe = 1'b0; // R20
      next_after_ack = 1'b0;
    end else if (start_det) begin
      next_state = BUS_RX;
      next_bit_cnt = 4'h0;
      next_byte_idx = 2'h0;
      next_cmd = CMD_NONE;
      next_hv_ok = hv_s;
      next_after_ack = 1'b0;
      next_sda_oe = 1'b0;
    end else if (stop_det) begin
      next_state = BUS_IDLE;
      next_sda_oe = 1'b0;
      next_after_ack = 1'b0;
    end else begin
      case (state)
        BUS_RX: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
            // The rise that opens a stop slot keeps the ack mark
            if (bit_cnt != 4'h0) begin
              next_after_ack = 1'b0; // R20
            end
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_state = BUS_ACK;
            next_sda_oe = ack_now;
            if (byte_idx == 2'h0) begin
              next_cmd = dec_cmd;
              next_rw = shreg[0];
            end else if (byte_idx == 2'h1) begin
              next_addr_ptr = shreg;
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bit_cnt = 4'h0;
            next_after_ack = sda_oe;
            next_byte_idx = (byte_idx == 2'h3) ? byte_idx : byte_idx + 2'h1;
            // Read forms hand over after the select
            next_state = (sda_oe && !(rw && byte_idx == 2'h0)) ? BUS_RX : BUS_SKIP; // R14 R15
            if (sda_oe && cmd == CMD_MEM && byte_idx >= 2'h2) begin
              // Page write wraps within the low address bits
              next_addr_ptr[`PAGE_BITS-1:0] = addr_ptr[`PAGE_BITS-1:0] + 4'h1; // R12
            end
          end
        end
        BUS_SKIP: next_sda_oe = 1'b0;
        default: next_state = BUS_IDLE;
      endcase
    end
  end

  // Byte engine registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= BUS_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      cmd <= CMD_NONE;
      rw <= 1'b0;
      addr_ptr <= 8'h00;
      hv_ok <= 1'b0;
      after_ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      cmd <= next_cmd;
      rw <= next_rw;
      addr_ptr <= next_addr_ptr;
      hv_ok <= next_hv_ok;
      after_ack <= next_after_ack;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write cycle and protection next state
  // ----------------------------------------
  always_comb begin
    next_protect_state = protect_state;
    next_pend_state = pend_state;
    next_pend_prot = pend_prot;
    next_write_busy = write_busy;
    next_mem_write_go = 1'b0;
    next_nv_loaded = 1'b1;
    next_wcnt = wcnt;
    if (!nv_loaded) begin
      next_protect_state = nv_protect_init; // R19
    end else if (write_busy) begin
      next_wcnt = wcnt + `WRITE_CNT_W'(1);
      if (wcnt == `WRITE_CNT_W'(WRITE_CYCLE_CYCLES - 1)) begin
        next_write_busy = 1'b0;
        next_wcnt = '0;
        if (pend_prot) begin
          next_protect_state = pend_state; // R08 R09 R11
        end
      end
    end else if (go_write) begin
      next_write_busy = 1'b1;
      next_wcnt = '0;
      next_pend_prot = (cmd != CMD_MEM);
      next_mem_write_go = (cmd == CMD_MEM); // R12
      case (cmd)
        CMD_SET: next_pend_state = PROT_SOFT;
        CMD_CLR: next_pend_state = PROT_NONE; // R08
        CMD_LOCK: next_pend_state = PROT_PERM; // R09
        default: next_pend_state = protect_state;
      endcase
    end
  end

  // Write cycle registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      protect_state <= PROT_NONE;
      pend_state <= PROT_NONE;
      pend_prot <= 1'b0;
      write_busy <= 1'b0;
      mem_write_go <= 1'b0;
      nv_loaded <= 1'b0;
      wcnt <= '0;
    end else begin
      protect_state <= next_protect_state;
      pend_state <= next_pend_state;
      pend_prot <= next_pend_prot;
      write_busy <= next_write_busy;
      mem_write_go <= next_mem_write_go;
      nv_loaded <= next_nv_loaded;
      wcnt <= next_wcnt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_LOCKED_PROT_NACK: assert property ( // R05
    (state == BUS_ACK && protect_state == PROT_PERM && byte_idx == 2'h0 &&
     cmd != CMD_MEM && cmd != CMD_NONE) |-> !sda_oe)
    else $error("locked device acknowledged a protect instruction");

  AST_LOW_HALF_DATA_NACK: assert property ( // R06
    (state == BUS_ACK && cmd == CMD_MEM && byte_idx >= 2'h2 &&
     !addr_ptr[`LOW_HALF_BIT] && protect_state != PROT_NONE) |-> !sda_oe)
    else $error("protected low half data byte acknowledged");

  AST_SOFT_SET_NACK: assert property ( // R07
    (state == BUS_ACK && cmd == CMD_SET && protect_state == PROT_SOFT) |-> !sda_oe)
    else $error("repeated set acknowledged");

  AST_INHIBIT_DATA_NACK: assert property ( // R10
    (state == BUS_ACK && byte_idx >= 2'h2 && $past(inhibit_s)) |-> !sda_oe)
    else $error("data acknowledged with write inhibit high");

  AST_READ_FORM_TAIL_NACK: assert property ( // R15
    (rw && byte_idx != 2'h0) |-> !sda_oe)
    else $error("read-form byte after select acknowledged");

  AST_SELECT_POSITION: assert property ( // R01
    (state == BUS_ACK && cmd == CMD_MEM && byte_idx == 2'h0 && sda_oe) |->
    $past(shreg[3:1]) == $past(pins_pos))
    else $error("select acknowledged for another position");

  AST_CYCLE_AFTER_STOP: assert property ( // R20
    $rose(write_busy) |-> $past(stop_det) && $past(after_ack))
    else $error("write cycle started without stop after acknowledge");

  AST_BUSY_SILENT: assert property ( // R20
    write_busy |=> !sda_oe)
    else $error("device answered during write cycle");

  AST_LOCK_HOLDS: assert property ( // R19
    (protect_state == PROT_PERM && nv_loaded) |=> protect_state == PROT_PERM)
    else $error("locked state left");

  AST_UNPROT_ACK: assert property ( // R11
    (scl_fall && state == BUS_RX && bit_cnt == 4'h8 && byte_idx == 2'h0 &&
     protect_state == PROT_NONE && dec_cmd != CMD_NONE) |=> sda_oe)
    else $error("unprotected device refused a select");

  COV_LOCK: cover property ($rose(protect_state == PROT_PERM));
  COV_MEM_WRITE: cover property (mem_write_go);
  COV_CLEAR: cover property ($fell(protect_state == PROT_SOFT));

endmodule : spd_write_protect_ack

// ### dv/i2c_master_model.sv
// Bus master model that drives the serial clock and data lines
`timescale 1ns/1ps

module i2c_master_model (
  // Clock
  input wire logic clk,
  // Bus lines, data released high through the pull-up
  output logic scl,
  output logic sda_m,
  input wire logic sda_wire
);
  // Half period of the bus clock in system clocks
  int half = 4;
  initial scl = 1'b1;
  initial sda_m = 1'b1;

  // One bit: data set after the fall, wire sampled late in the high phase
  task bit_io(input logic b, output logic r);
    @(posedge clk);
    sda_m <= b;
    repeat (half - 1) @(posedge clk);
    scl <= 1'b1;
    repeat (half - 1) @(posedge clk);
    @(negedge clk);
    r = sda_wire;
    @(posedge clk);
    scl <= 1'b0;
  endtask : bit_io

  // Whole frame: start, nb bytes MSB first, ack bits collected, stop
  task xfer(input logic [7:0] sel, input logic [7:0] adr, input logic [7:0] dat,
            input int nb, output logic [7:0] acks);
    logic [7:0] b;
    logic r;
    acks = 8'h00;
    @(posedge clk);
    sda_m <= 1'b0;
    repeat (half) @(posedge clk);
    scl <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      b = (i == 0) ? sel : (i == 1) ? adr : dat;
      for (int k = 7; k >= 0; k--) bit_io(b[k], r);
      bit_io(1'b1, r);
      acks[i] = !r;
    end
    // Stop in the slot right after the last ack slot
    @(posedge clk);
    sda_m <= 1'b0;
    repeat (half) @(posedge clk);
    scl <= 1'b1;
    repeat (half) @(posedge clk);
    sda_m <= 1'b1;
    repeat (half) @(posedge clk);
  endtask : xfer
endmodule : i2c_master_model

// ### dv/spd_write_protect_ack_tb.sv
// Self-checking bench for the write-protect and acknowledge block
`timescale 1ns/1ps
`include "spd_wp_cfg.svh"

module spd_write_protect_ack_tb
  import spd_wp_pkg::*;
;
  localparam int WCC = 400;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] pos = 3'h4;
  logic hv = 1'b0;
  logic inhib = 1'b0;
  prot_state_t nv_init = PROT_NONE;
  logic scl, sda_m, sda_out, sda_oe, write_busy, mem_write_go;
  prot_state_t protect_state;
  wire sda_bus = sda_m & ~(sda_oe & ~sda_out);
  int err_total = 0;
  int n_compared = 0;
  int seed = 32'h8E28;
  int m_lvl = 0;
  int n_go = 0;
  int cyc = 0;
  int ntest = 0;

  // Clock, pulse counter and hang limit
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (mem_write_go === 1'b1) n_go <= n_go + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end

  spd_write_protect_ack #(.WRITE_CYCLE_CYCLES(WCC)) spd_write_protect_ack_inst (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_sel_bit0(pos[0]), .chip_sel_bit1(pos[1]),
    .chip_sel_bit2(pos[2]), .e0_high_voltage_level(hv), .write_inhibit_in(inhib),
    .nv_protect_init(nv_init), .protect_state(protect_state),
    .write_busy(write_busy), .mem_write_go(mem_write_go)
  );

  i2c_master_model i2c_master_model_inst (
    .clk(clk), .scl(scl), .sda_m(sda_m), .sda_wire(sda_bus)
  );

  // Compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Counts and verdict
  task stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // One frame against the model: k 0 set, 1 clear, 2 lock, 3 memory, 4 foreign
  task op(input int k, input logic rw, input logic w, input logic h,
          input logic [7:0] adr, input int nb, input logic drop);
    logic [7:0] sel, acks, ex;
    logic v, blk, dok, go;
    int g0;
    ntest++;
    @(posedge clk);
    inhib <= w;
    hv <= h;
    repeat (4) @(posedge clk);
    sel = {(k > 2) ? `DEV_TYPE_MEM : `DEV_TYPE_PROT, (k == 0) ? `SET_SEL_BITS :
           (k == 1) ? `CLR_SEL_BITS : (k == 4) ? ~pos : pos, rw};
    v = (k == 2 || k == 3 || (k < 2 && h));
    blk = k < 3 && (m_lvl == 3 || (m_lvl == 1 && k == 0));
    dok = !w && !(k == 3 && m_lvl != 0 && adr < 8'h80);
    ex = 8'h00;
    if (v && !blk) ex = rw ? 8'h01 : dok ? 8'hFF >> (8 - nb) : 8'h03;
    go = !rw && v && !blk && dok && nb > 2 && !drop;
    g0 = n_go;
    fork
      i2c_master_model_inst.xfer(sel, adr, 8'($random(seed)), nb, acks);
      if (drop) begin
        repeat (120) @(posedge clk);
        hv <= 1'b0;
      end
    join
    if (!drop) check(acks, ex);
    repeat (12) @(posedge clk);
    check({7'h0, write_busy}, {7'h0, go});
    check(8'(n_go - g0), {7'h0, go && k == 3});
    if (go) begin
      i2c_master_model_inst.xfer(sel, adr, 8'h00, 1, acks);
      check(acks, 8'h00);
      for (int t = 0; t < 1000 && write_busy !== 1'b0; t++) @(posedge clk);
      m_lvl = (k == 0) ? 1 : (k == 1) ? 0 : (k == 2) ? 3 : m_lvl;
      repeat (2) @(posedge clk);
    end
    check({6'h0, protect_state}, 8'(m_lvl));
    nv_init <= prot_state_t'(m_lvl[1:0]);
    $display("test %0d done", ntest);
  endtask : op

  // Main sequence
  initial begin
    pos = 3'(4 + ($random(seed) & 3));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    op(3, 0, 0, 0, 8'($random(seed)) & 8'h7F, 5, 0);
    op(3, 0, 1, 0, 8'h00, 3, 0);
    for (int k = 0; k < 3; k++) op(k, 1, 0, 1, 8'h00, 3, 0);
    op(4, 0, 0, 0, 8'h10, 3, 0);
    op(0, 0, 1, 1, 8'h00, 3, 0);
    op(0, 0, 0, 0, 8'h00, 3, 0);
    op(0, 0, 0, 1, 8'h00, 3, 0);
    op(0, 0, 0, 1, 8'h00, 3, 0);
    op(0, 0, 1, 1, 8'h00, 3, 0);
    for (int k = 0; k < 3; k++) op(k, 1, 0, 1, 8'h00, 3, 0);
    op(3, 0, 0, 0, 8'h7F, 3, 0);
    op(3, 0, 0, 0, 8'($random(seed)) | 8'h80, 4, 0);
    op(1, 0, 1, 1, 8'h00, 3, 0);
    op(1, 0, 0, 1, 8'h00, 3, 0);
    op(0, 0, 0, 1, 8'h00, 3, 1);
    op(3, 0, 0, 0, 8'h20, 2, 0);
    op(0, 0, 0, 1, 8'h00, 3, 0);
    // Power loss in mid-run keeps the stored level
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({6'h0, protect_state}, 8'h01);
    i2c_master_model_inst.half = 12;
    op(2, 0, 0, 0, 8'h00, 3, 0);
    i2c_master_model_inst.half = 4;
    for (int i = 0; i < 6; i++) op(i % 3, 1'(i / 3), 1'($random(seed)), 1, 8'h00, 3, 0);
    op(3, 0, 0, 0, 8'h05, 3, 0);
    stop_test;
  end
endmodule : spd_write_protect_ack_tb
